//--- logic/mio_access.sv
/*
 processor-side access to the 64-module i/o space: direct ports 56..63, module select,
 indirect port access, word address register store, and the built-in port at module 63.
 assumes one operation per cycle on op with its operands; external modules other than
 the built-in port are reached through the ext_* outputs and answer on ext_rd_data.
*/
// Notes on behaviour
// [R01] ports are 8 bits, latched until rewritten
// [R02] port read is latch OR pins
// [R03] reset clears every output latch
// [R04] direct load and store move accumulator
// [R05] direct code plus 56 forms module
// [R06] built-in port always at module 63
// [R07] built-in port reads all 8 bits
// [R08] built-in port drives upper nibble only
// [R09] select store loads module-select register
// [R10] module select changes only when rewritten
// [R11] indirect access reaches all 64 modules
// [R12] word address store picks 256 words
// [R13] built-in low nibble reads pins only
`timescale 1ns/1ns
module mio_access
	import mio_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// operation from the processor
	input wire logic [2:0] op,
	input wire logic [2:0] port_code,
	input wire logic [7:0] acc_in,
	// accumulator result
	output logic [7:0] acc_out,
	output logic acc_valid,
	// built-in port pins
	input wire logic [7:0] bport_in,
	output logic [7:0] bport_out,
	output logic [7:0] bport_oe,
	// external module bus
	output logic [5:0] ext_module,
	output logic ext_rd,
	output logic ext_wr,
	output logic [7:0] ext_wr_data,
	output logic ext_waddr_wr,
	input wire logic [7:0] ext_rd_data,
	// state view
	output logic [5:0] module_select,
	output logic [7:0] word_addr
);
	mio_op_t op_w;
	logic [5:0] sel_q, sel_d;
	logic [7:0] waddr_q, waddr_d;
	logic [7:0] acc_q, acc_d;
	logic valid_q, valid_d;
	logic pend_q, pend_d;
	logic [5:0] emod_q, emod_d;
	logic erd_q, erd_d;
	logic ewr_q, ewr_d;
	logic ewa_q, ewa_d;
	logic [7:0] ewd_q, ewd_d;
	logic [7:0] bout_q, bout_d;
	logic [7:0] boe_q, boe_d;
	logic [5:0] target;
	logic is_load, is_store;
	logic hit_builtin;
	logic bport_wr;
	logic [7:0] bport_rd;
	logic [7:0] bport_pin;
	logic [7:0] bport_en;

	// direct code offset into the top eight modules
	function automatic logic [5:0] direct_module(input logic [2:0] code);
		direct_module = MIO_DIRECT_BASE + {3'b000, code}; // [R05]
	endfunction

	function automatic logic is_direct_op(input mio_op_t o);
		is_direct_op = (o == MIO_OP_LOAD_DIRECT) || (o == MIO_OP_STORE_DIRECT);
	endfunction

	function automatic logic is_load_op(input mio_op_t o);
		is_load_op = (o == MIO_OP_LOAD_DIRECT) || (o == MIO_OP_LOAD_INDIRECT);
	endfunction

	function automatic logic is_store_op(input mio_op_t o);
		is_store_op = (o == MIO_OP_STORE_DIRECT) || (o == MIO_OP_STORE_INDIRECT);
	endfunction

	// the direct window must stay inside the module space
	if ((MIO_DIRECT_BASE + 7) > (MIO_NUM_MODULES - 1)) begin : g_bad_base
		$error("direct port window leaves the module space");
	end

	assign op_w = mio_op_t'(op);
	assign is_load = is_load_op(op_w);
	assign is_store = is_store_op(op_w);

	// module reached this cycle: direct code or module select
	always_comb begin
		target = sel_q; // [R11]
		if (is_direct_op(op_w)) begin
			target = direct_module(port_code);
		end
	end

	assign hit_builtin = (target == MIO_BUILTIN_MOD); // [R06]
	assign bport_wr = is_store && hit_builtin; // [R04]

	mio_port #(
		.OUT_MASK(MIO_BUILTIN_OUT_MASK)
	) u_bport (
		.clk(clk),
		.rst(rst),
		.wr_en(bport_wr),
		.wr_data(acc_in),
		.pin_in(bport_in),
		.pin_out(bport_pin),
		.pin_oe(bport_en),
		.rd_data(bport_rd)
	);

	// module select and word address
	always_comb begin
		sel_d = sel_q; // [R10]
		waddr_d = waddr_q;
		if (op_w == MIO_OP_STORE_SELECT) begin
			sel_d = acc_in[5:0]; // [R09]
		end
		if (op_w == MIO_OP_STORE_WADDR) begin
			waddr_d = acc_in; // [R12]
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sel_q <= MIO_SEL_RST;
			waddr_q <= MIO_WADDR_RST;
		end else begin
			sel_q <= sel_d;
			waddr_q <= waddr_d;
		end
	end

	// accumulator result; an external answer lands one cycle after its read
	always_comb begin
		acc_d = acc_q;
		valid_d = 1'b0;
		pend_d = is_load && !hit_builtin;
		if (is_load && hit_builtin) begin
			acc_d = bport_rd; // [R04] [R07]
			valid_d = 1'b1;
		end
		if (pend_q) begin
			acc_d = ext_rd_data; // [R02]
			valid_d = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc_q <= MIO_LATCH_RST;
			valid_q <= 1'b0;
			pend_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			valid_q <= valid_d;
			pend_q <= pend_d;
		end
	end

	// external module bus strobes, one cycle each
	always_comb begin
		emod_d = emod_q;
		erd_d = 1'b0;
		ewr_d = 1'b0;
		ewa_d = 1'b0;
		ewd_d = ewd_q;
		unique case (op_w)
			MIO_OP_STORE_WADDR: begin
				emod_d = sel_q;
				ewd_d = acc_in;
				ewa_d = 1'b1;
			end
			MIO_OP_LOAD_DIRECT, MIO_OP_LOAD_INDIRECT: begin
				if (!hit_builtin) begin
					emod_d = target;
					erd_d = 1'b1;
				end
			end
			MIO_OP_STORE_DIRECT, MIO_OP_STORE_INDIRECT: begin
				if (!hit_builtin) begin
					emod_d = target; // [R04]
					ewd_d = acc_in;
					ewr_d = 1'b1;
				end
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			emod_q <= MIO_SEL_RST;
			erd_q <= 1'b0;
			ewr_q <= 1'b0;
			ewa_q <= 1'b0;
			ewd_q <= MIO_LATCH_RST;
		end else begin
			emod_q <= emod_d;
			erd_q <= erd_d;
			ewr_q <= ewr_d;
			ewa_q <= ewa_d;
			ewd_q <= ewd_d;
		end
	end

	// built-in port pins, registered so the outputs come from flip-flops
	always_comb begin
		bout_d = bport_pin;
		boe_d = bport_en; // [R08]
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bout_q <= MIO_LATCH_RST;
			boe_q <= MIO_LATCH_RST;
		end else begin
			bout_q <= bout_d;
			boe_q <= boe_d;
		end
	end

	assign bport_out = bout_q;
	assign bport_oe = boe_q;
	assign acc_out = acc_q;
	assign acc_valid = valid_q;
	assign ext_module = emod_q;
	assign ext_rd = erd_q;
	assign ext_wr = ewr_q;
	assign ext_wr_data = ewd_q;
	assign ext_waddr_wr = ewa_q;
	assign module_select = sel_q;
	assign word_addr = waddr_q;
endmodule

//--- logic/mio_pkg.sv
/*
 package for the module i/o port access block: module map, port widths, reset values, operation codes.
 assumes a single system clock and an asynchronous active-high reset.
*/
package mio_pkg;
	localparam int MIO_DATA_W = 8;
	localparam int MIO_MOD_W = 6;
	localparam int MIO_CODE_W = 3;
	localparam int MIO_NUM_MODULES = 64;
	localparam logic [5:0] MIO_DIRECT_BASE = 6'h38;
	localparam logic [5:0] MIO_BUILTIN_MOD = 6'h3F;
	localparam logic [7:0] MIO_LATCH_RST = 8'h00;
	localparam logic [5:0] MIO_SEL_RST = 6'h00;
	localparam logic [7:0] MIO_WADDR_RST = 8'h00;
	localparam logic [7:0] MIO_BUILTIN_OUT_MASK = 8'hF0;

	typedef enum logic [2:0] {
		MIO_OP_NONE = 3'b000,
		MIO_OP_LOAD_DIRECT = 3'b001,
		MIO_OP_STORE_DIRECT = 3'b010,
		MIO_OP_STORE_SELECT = 3'b011,
		MIO_OP_LOAD_INDIRECT = 3'b100,
		MIO_OP_STORE_INDIRECT = 3'b101,
		MIO_OP_STORE_WADDR = 3'b110
	} mio_op_t;
endpackage

//--- logic/mio_port.sv
/*
 one 8-bit latched bidirectional port: output latch, pin synchroniser, wire-or readback.
 assumes pins come from outside the clock domain; writes come from logic on clk.
*/
`timescale 1ns/1ns
module mio_port
	import mio_pkg::*;
#(
	parameter logic [7:0] OUT_MASK = 8'hFF
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// write side
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	// pins
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	// readback
	output logic [7:0] rd_data
);
	logic [7:0] latch_q, latch_d;
	logic [7:0] sync1_q, sync2_q;

	always_comb begin
		latch_d = latch_q;
		if (wr_en) begin
			latch_d = wr_data & OUT_MASK; // [R01] [R08]
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			latch_q <= MIO_LATCH_RST; // [R03]
			sync1_q <= MIO_LATCH_RST;
			sync2_q <= MIO_LATCH_RST;
		end else begin
			latch_q <= latch_d;
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
		end
	end

	assign pin_out = latch_q;
	assign pin_oe = latch_q & OUT_MASK;
	assign rd_data = latch_q | sync2_q; // [R02] [R07] [R13]
endmodule

//--- verif/mio_chk.sv
/* port checks for mio_access
 assumes clk with async high rst */
`timescale 1ns/1ns
module mio_chk import mio_pkg::*; (
	input wire logic clk, rst, acc_valid, ext_rd, ext_wr, ext_waddr_wr,
	input wire logic [2:0] op, port_code,
	input wire logic [5:0] ext_module, module_select,
	input wire logic [7:0] acc_in, acc_out, bport_out, ext_rd_data, word_addr
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_sd; op == 3'h2 && port_code != 3'h7 |=> ext_wr && ext_module == 6'h38 + $past(port_code); endproperty
	a_sd: assert property (p_sd) else $error("direct store module wrong");
	property p_b63; op == 3'h2 && port_code == 3'h7 |=> !ext_wr; endproperty
	a_b63: assert property (p_b63) else $error("built-in store on ext bus");
	property p_nib; bport_out[3:0] == 4'h0; endproperty
	a_nib: assert property (p_nib) else $error("low nibble driven");
	property p_sel; op == 3'h3 |=> module_select == $past(acc_in[5:0]); endproperty
	a_sel: assert property (p_sel) else $error("select not loaded");
	property p_hold; op != 3'h3 |=> $stable(module_select); endproperty
	a_hold: assert property (p_hold) else $error("select changed");
	property p_ind; op == 3'h4 && module_select != 6'h3F |=> ext_rd && ext_module == module_select; endproperty
	a_ind: assert property (p_ind) else $error("indirect module wrong");
	property p_ld; ext_rd |=> acc_valid && acc_out == $past(ext_rd_data); endproperty
	a_ld: assert property (p_ld) else $error("load data wrong");
	property p_wa; op == 3'h6 |=> ext_waddr_wr && word_addr == $past(acc_in); endproperty
	a_wa: assert property (p_wa) else $error("word address wrong");
	property p_bld; op == 3'h1 && port_code == 3'h7 |=> acc_valid && !ext_rd; endproperty
	a_bld: assert property (p_bld) else $error("built-in load not answered");
	c_ld: cover property (acc_valid);
	c_ind: cover property (ext_rd);
	c_wa: cover property (ext_waddr_wr);
endmodule
bind mio_access mio_chk mio_chk_inst (.*);

//--- verif/mio_periph.sv
/* peripheral model: pins and external port latches
 assumes design ext bus timing on clk */
`timescale 1ns/1ns
module mio_periph import mio_pkg::*; (
	input wire logic clk, rst, ext_wr,
	input wire logic [5:0] ext_module,
	input wire logic [7:0] bport_out, bport_oe, pins, ext_wr_data,
	output logic [7:0] bport_in, ext_rd_data
);
	logic [7:0] lat [64];
	assign bport_in = pins | (bport_out & bport_oe);
	assign ext_rd_data = lat[ext_module] | pins;
	always @(posedge clk or posedge rst) begin
		if (rst) lat <= '{default: 8'h00};
		else if (ext_wr) lat[ext_module] <= ext_wr_data;
	end
endmodule

//--- verif/mio_access_tb.sv
/* bench for mio_access with peripheral model
 assumes 25 MHz clk, async high rst */
`timescale 1ns/1ns
module mio_access_tb;
	import mio_pkg::*;
	logic clk, rst, acc_valid, ext_rd, ext_wr, ext_waddr_wr;
	logic [2:0] op, port_code;
	logic [5:0] ext_module, module_select;
	logic [7:0] acc_in, pins, acc_out, bport_in, bport_out, bport_oe, ext_wr_data, ext_rd_data, word_addr;
	int bad_count, cmp_count;
	// op, code, acc, pins, expected load
	logic [29:0] rows [11] = '{{3'h1, 3'h0, 8'h00, 8'h11, 8'h11}, {3'h2, 3'h0, 8'hA5, 8'h00, 8'h00},
		{3'h1, 3'h0, 8'h00, 8'h42, 8'hE7}, {3'h2, 3'h7, 8'h5A, 8'h00, 8'h00}, {3'h1, 3'h7, 8'h00, 8'h03, 8'h53},
		{3'h3, 3'h0, 8'h05, 8'h00, 8'h00}, {3'h5, 3'h0, 8'h3C, 8'h00, 8'h00}, {3'h4, 3'h0, 8'h00, 8'h00, 8'h3C},
		{3'h2, 3'h5, 8'h81, 8'h00, 8'h00}, {3'h4, 3'h0, 8'h00, 8'h40, 8'h7C}, {3'h6, 3'h0, 8'h9E, 8'h00, 8'h00}};
	mio_access mio_access_inst (.*);
	mio_periph mio_periph_inst (.*);
	task cyc(int n);
		repeat (n) @(negedge clk);
	endtask
	task chk(string n, logic [7:0] e, logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	initial begin
		#20000;
		bad_count++;
		print_verdict;
	end
	initial begin
		rst = 1;
		{op, port_code, acc_in, pins} = 22'h0;
		cyc(3);
		rst = 0;
		foreach (rows[i]) begin
			pins = rows[i][15:8];
			cyc(3);
			{op, port_code, acc_in} = rows[i][29:16];
			cyc(1);
			op = 3'h0;
			cyc(3);
			if (rows[i][29:27] inside {3'h1, 3'h4}) chk("acc_out", rows[i][7:0], acc_out);
		end
		chk("word_addr", 8'h9E, word_addr);
		chk("module_select", 8'h05, {2'h0, module_select});
		chk("bport_out", 8'h50, bport_out);
		chk("bport_oe", 8'h50, bport_oe);
		chk("ext_wr_data", 8'h9E, ext_wr_data);
		chk("ext_module", 8'h05, {2'h0, ext_module});
		rst = 1;
		cyc(1);
		rst = 0;
		cyc(3);
		chk("bport_out", 8'h00, bport_out);
		chk("module_select", 8'h00, {2'h0, module_select});
		chk("bport_oe", 8'h00, bport_oe);
		chk("word_addr", 8'h00, word_addr);
		print_verdict;
	end
endmodule
